/* File: inc/serial_ctrl_params.svh */
// Constants of the serial control port: offsets, fields, reset values.
// Assumes inclusion by the core and test files.
`ifndef SERIAL_CTRL_PARAMS_SVH
`define SERIAL_CTRL_PARAMS_SVH
`define WORD_BITS        16
`define DATA_BITS        9
`define ADDR_BITS        7
`define DEV_ADDR         7'h1A
`define SOFT_RESET_ADDR  7'h00
`define PIN_CTRL_ADDR    7'h08
`define PIN_CTRL_RESET   9'h000
`define SEL_LSB          0
`define SEL_MSB          2
`define POL_BIT          3
`define DIV_LSB          4
`define DIV_MSB          5
`define SEL_STROBE       3'h0
`define SEL_LOOP_CLK     3'h4
`endif

/* File: inc/serial_ctrl_pkg.sv */
// Types shared by the serial control port files.
// Assumes the params header is on the include path.
package serial_ctrl_pkg;
  typedef enum logic {TWO_WIRE, THREE_WIRE} ctrl_mode_type;
endpackage

/* File: core/loop_clock_divider.sv */
// Divides the loop clock reference by 1..4 for the shared pin.
// Assumes loopClkRef is a synchronous enable at sys_clk rate.
`timescale 1ns/1ps
`include "serial_ctrl_params.svh"
module loop_clock_divider
  import serial_ctrl_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       loopClkRef,
  input  wire logic [1:0] divCode,
  output logic            divClk
);
  logic [1:0] count_q;
  logic       out_q;
  wire        wrap = (count_q == divCode);

  // Output toggles each divCode+1 reference edges
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count_q <= 2'h0;
      out_q   <= 1'b0;
    end else if (loopClkRef) begin
      count_q <= wrap ? 2'h0 : count_q + 2'h1;
      out_q   <= wrap ? ~out_q : out_q;
    end
  end
  assign divClk = out_q;
endmodule // loop_clock_divider

/* File: core/serial_control_port.sv */
// Serial control port: 3-wire and 2-wire write-only register access.
// Assumes pins synchronous to sys_clk; decoded register lines are outputs.
//
// Contract
// - Mode pin low selects 2-wire, high selects 3-wire protocol.
// - Word is 16 bits: 7 register address bits, 9 data bits.
// - 3-wire mode shifts one data bit per serial clock rise.
// - 3-wire strobe rise commits last 16 shifted bits.
// - 2-wire target only; start is data falling while clock high.
// - After start, shift address plus read/write bit, MSB first.
// - Matching address is acknowledged by pulling data low.
// - Mismatch or read request returns to idle.
// - First data byte is bits 15..8, acknowledged.
// - Second data byte is bits 7..0, acknowledged.
// - Stop is data rising while clock high; back to idle.
// - Start out of sequence restarts the address phase; stop out of sequence forces idle.
// - Target address fixed at 0011010.
// - Write to register 0 restores all defaults.
// - Power-on reset loads defaults.
// - Bits 5:4 divide loop clock by 1 to 4.
// - Shared pin general-purpose only in 2-wire mode.
// - Three-bit field selects shared pin role.
`timescale 1ns/1ps
`include "serial_ctrl_params.svh"
module serial_control_port
  import serial_ctrl_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        modePin,
  input  wire logic        serialClk,
  input  wire logic        serialDataIn,
  output logic             serialDataOut,
  output logic             serialDataOe_n,
  input  wire logic        strobeIn,
  output logic             generalPinOut,
  output logic             generalPinOe_n,
  input  wire logic        loopClkRef,
  input  wire logic        jackDetect,
  input  wire logic        tempOk,
  input  wire logic        autoMuteActive,
  input  wire logic        loopLock,
  output logic             wordValid,
  output logic [6:0]       wordAddr,
  output logic [8:0]       wordData,
  output logic [8:0]       pinControl
);
  // ==========================================================
  // Input synchronisers and edge detection
  logic [2:0] sclSync_q, sdaSync_q, csSync_q;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sclSync_q <= 3'h0;
      sdaSync_q <= 3'h7;
      csSync_q  <= 3'h0;
    end else begin
      sclSync_q <= {sclSync_q[1:0], serialClk};
      sdaSync_q <= {sdaSync_q[1:0], serialDataIn};
      csSync_q  <= {csSync_q[1:0], strobeIn};
    end
  end
  // Edges use stages 1 and 2 only; stage 0 feeds stage 1 alone
  wire sclRise = sclSync_q[1] & ~sclSync_q[2];
  wire sclFall = ~sclSync_q[1] & sclSync_q[2];
  wire sclHigh = sclSync_q[1] & sclSync_q[2];
  wire sdaBit  = sdaSync_q[1];
  wire csRise  = csSync_q[1] & ~csSync_q[2];
  wire startCond = sclHigh & ~sdaSync_q[1] & sdaSync_q[2];
  wire stopCond  = sclHigh & sdaSync_q[1] & ~sdaSync_q[2];

  ctrl_mode_type mode;
  assign mode = modePin ? THREE_WIRE : TWO_WIRE;

  // ==========================================================
  // 3-wire shifter
  logic [15:0] shift3_q;
  always_ff @(posedge sys_clk) begin
    if (reset)
      shift3_q <= 16'h0000;
    else if (mode == THREE_WIRE && sclRise)
      shift3_q <= {shift3_q[14:0], sdaBit};
  end
  wire commit3 = (mode == THREE_WIRE) && csRise;

  // ==========================================================
  // 2-wire target engine
  typedef enum logic [2:0] {IDLE, ADDR, ACK_A, BYTE_HI, ACK_H, BYTE_LO, ACK_L,
                            WAIT_STOP} tw_state_type;
  tw_state_type state_q, state_d;
  logic [3:0]  bitCnt_q, bitCnt_d;
  logic [7:0]  byte_q, byte_d;
  logic [15:0] word2_q, word2_d;
  logic        ackDrive_q, ackDrive_d;
  logic        commit2;

  wire [7:0] byteNext = {byte_q[6:0], sdaBit};
  // Decided on the falling clock, when byte_q already holds all eight bits
  wire       addrHit  = (byte_q[7:1] == `DEV_ADDR) && !byte_q[0];

  always_comb begin
    state_d    = state_q;
    bitCnt_d   = bitCnt_q;
    byte_d     = byte_q;
    word2_d    = word2_q;
    ackDrive_d = ackDrive_q;
    commit2    = 1'b0;
    if (mode != TWO_WIRE) begin
      state_d    = IDLE;
      ackDrive_d = 1'b0;
    end else if (startCond) begin
      state_d    = ADDR;
      bitCnt_d   = 4'h0;
      ackDrive_d = 1'b0;
    end else if (stopCond) begin
      state_d    = IDLE;
      ackDrive_d = 1'b0;
    end else begin
      unique case (state_q)
        IDLE, WAIT_STOP: ;
        ADDR, BYTE_HI, BYTE_LO: begin
          if (sclRise) begin
            byte_d   = byteNext;
            bitCnt_d = bitCnt_q + 4'h1;
          end
          if (sclFall && bitCnt_q == 4'h8) begin
            bitCnt_d = 4'h0;
            if (state_q == ADDR) begin
              state_d    = addrHit ? ACK_A : IDLE;
              ackDrive_d = addrHit;
            end else if (state_q == BYTE_HI) begin
              word2_d[15:8] = byte_q;
              state_d       = ACK_H;
              ackDrive_d    = 1'b1;
            end else begin
              word2_d[7:0] = byte_q;
              state_d      = ACK_L;
              ackDrive_d   = 1'b1;
            end
          end
        end
        ACK_A, ACK_H, ACK_L: begin
          if (sclFall) begin
            ackDrive_d = 1'b0;
            bitCnt_d   = 4'h0;
            if (state_q == ACK_A)
              state_d = BYTE_HI;
            else if (state_q == ACK_H)
              state_d = BYTE_LO;
            else begin
              state_d = WAIT_STOP;
              commit2 = 1'b1;
            end
          end
        end
      endcase
    end
  end
  // Byte decision deferred to the 8th falling clock so ACK fits the 9th pulse

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q    <= IDLE;
      bitCnt_q   <= 4'h0;
      byte_q     <= 8'h00;
      word2_q    <= 16'h0000;
      ackDrive_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      bitCnt_q   <= bitCnt_d;
      byte_q     <= byte_d;
      word2_q    <= word2_d;
      ackDrive_q <= ackDrive_d;
    end
  end

  // ==========================================================
  // Word commit and registers
  wire        commit   = commit3 | commit2;
  wire [15:0] word     = commit3 ? shift3_q : word2_d;
  wire [6:0]  cmdAddr  = word[15:9];
  wire [8:0]  cmdData  = word[8:0];
  wire        softRst  = commit && cmdAddr == `SOFT_RESET_ADDR;
  wire        pinWrite = commit && cmdAddr == `PIN_CTRL_ADDR;

  logic [8:0] pinCtrl_q;
  logic       wordValid_q;
  logic [6:0] wordAddr_q;
  logic [8:0] wordData_q;
  always_ff @(posedge sys_clk) begin
    if (reset || softRst)
      pinCtrl_q <= `PIN_CTRL_RESET;
    else if (pinWrite)
      pinCtrl_q <= cmdData;
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wordValid_q <= 1'b0;
      wordAddr_q  <= 7'h00;
      wordData_q  <= 9'h000;
    end else begin
      wordValid_q <= commit;
      wordAddr_q  <= commit ? cmdAddr : wordAddr_q;
      wordData_q  <= commit ? cmdData : wordData_q;
    end
  end

  // ==========================================================
  // Shared pin function
  wire [2:0] pinSel = pinCtrl_q[`SEL_MSB:`SEL_LSB];
  logic      divClk;
  loop_clock_divider u_div (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .loopClkRef (loopClkRef),
    .divCode    (pinCtrl_q[`DIV_MSB:`DIV_LSB]),
    .divClk     (divClk)
  );
  // Reserved codes drive the polarity bit level rather than float
  wire pinFunc = (pinSel == 3'h1) ? jackDetect :
                 (pinSel == 3'h2) ? tempOk :
                 (pinSel == 3'h3) ? autoMuteActive :
                 (pinSel == `SEL_LOOP_CLK) ? divClk :
                 (pinSel == 3'h5) ? loopLock : 1'b0;
  wire pinDrive = (mode == TWO_WIRE) && pinSel != `SEL_STROBE;

  logic genOut_q, genOe_n_q;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      genOut_q  <= 1'b0;
      genOe_n_q <= 1'b1;
    end else begin
      genOut_q  <= pinFunc ^ pinCtrl_q[`POL_BIT];
      genOe_n_q <= ~pinDrive;
    end
  end

  assign serialDataOut  = 1'b0;
  assign serialDataOe_n = ~ackDrive_q;
  assign generalPinOut  = genOut_q;
  assign generalPinOe_n = genOe_n_q;
  assign wordValid      = wordValid_q;
  assign wordAddr       = wordAddr_q;
  assign wordData       = wordData_q;
  assign pinControl     = pinCtrl_q;
endmodule // serial_control_port

/* File: test/serial_ctrl_properties.sv */
// Assertions on the control port pins.
// Assumes a bind onto serial_control_port.
`timescale 1ns/1ps
`include "serial_ctrl_params.svh"
module serial_ctrl_checker (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       modePin,
  input wire logic       serialDataOe_n,
  input wire logic       generalPinOe_n,
  input wire logic       wordValid,
  input wire logic [6:0] wordAddr,
  input wire logic [8:0] wordData,
  input wire logic [8:0] pinControl
);
  // ==========
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  ack_mode_a: assert property (!serialDataOe_n |-> !$past(modePin))
    else $error("ack in 3-wire");
  gp_mode_a: assert property (!generalPinOe_n |-> !modePin)
    else $error("pin in 3-wire");
  gp_sel_a: assert property (pinControl[2:0] == 3'h0 &&
    $past(pinControl[2:0]) == 3'h0 |-> generalPinOe_n) else $error("strobe pin driven");
  valid_pulse_a: assert property (wordValid |=> !wordValid) else $error("long valid");
  soft_reset_a: assert property (wordValid && wordAddr == `SOFT_RESET_ADDR
    |-> ##1 pinControl == `PIN_CTRL_RESET) else $error("no soft reset");
  pin_write_a: assert property (wordValid && wordAddr == `PIN_CTRL_ADDR
    |=> pinControl == $past(wordData)) else $error("pin reg missed");
  // Register and valid pulse update on the same edge
  pin_hold_a: assert property (!wordValid |-> $stable(pinControl))
    else $error("pin reg moved");
  word_hold_a: assert property (!wordValid |-> $stable({wordAddr, wordData}))
    else $error("word moved");
  ack_len_a: assert property ($fell(serialDataOe_n) |-> !serialDataOe_n [*4])
    else $error("short ack");
endmodule // serial_ctrl_checker

/* File: test/serial_host_model.sv */
// Host model driving serial clock, data and strobe.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
module serial_host_model (
  input  wire logic sys_clk,
  input  wire logic sdaLevel,
  output logic      serialClk,
  output logic      sdaDrive,
  output logic      strobeOut
);
  // ==========
  // Phases of 5 cycles, slow enough for the synchronisers
  initial begin
    serialClk = 1'b0;
    sdaDrive = 1'b1;
    strobeOut = 1'b0;
  end
  task automatic ph(input logic c, input logic d);
    @(posedge sys_clk);
    serialClk <= c;
    sdaDrive <= d;
    repeat (4) @(posedge sys_clk);
  endtask
  // Data never moves in the clock's falling cycle: no false start
  task automatic bit2(input logic b);
    ph(1'b0, sdaDrive);
    ph(1'b0, b);
    ph(1'b1, b);
  endtask
  task automatic wr2(input logic [23:0] f, input int n, output int ack);
    ack = 0;
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    for (int i = 0; i < n; i++) begin
      bit2(f[23-i]);
      if (i % 8 == 7) begin
        bit2(1'b1);
        ack += int'(sdaLevel === 1'b0);
      end
    end
    ph(1'b0, sdaDrive);
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  task automatic wr3(input logic [16:0] w);
    for (int i = 16; i >= 0; i--) begin
      ph(1'b0, w[i]);
      ph(1'b1, w[i]);
    end
    ph(1'b0, 1'b1);
    @(posedge sys_clk) strobeOut <= 1'b1;
    repeat (6) @(posedge sys_clk);
    strobeOut <= 1'b0;
  endtask
endmodule // serial_host_model

/* File: test/tb.sv */
// Bench driving the control port through the host model.
// Assumes design, checker and host model compiled first.
`timescale 1ns/1ps
`include "serial_ctrl_params.svh"
`define CHK(n, e, s) begin numChecks++; if ((s) !== (e)) begin fails++; \
  $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module tb;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        modePin = 1'b1;
  logic        jackDetect = 1'b0;
  logic        loopRef = 1'b0;
  logic        g;
  int          edges = 0;
  logic        sdaOut, sdaOe_n, gpOut, gpOe_n, sclk, hostSda, strobe, wordValid;
  logic [6:0]  wordAddr;
  logic [8:0]  wordData, pinControl;
  logic [8:0]  expPin = `PIN_CTRL_RESET;
  logic [15:0] lastWord, w;
  int          fails = 0, numChecks = 0, words = 0, expWords = 0, ack = 0;
  wire         sda = hostSda & (sdaOe_n | sdaOut);
  // ==========
  // Design, host, monitor
  always #5 sys_clk = ~sys_clk;
  serial_control_port dut (.sys_clk(sys_clk), .reset(reset), .modePin(modePin),
    .serialClk(sclk), .serialDataIn(sda), .serialDataOut(sdaOut), .serialDataOe_n(sdaOe_n),
    .strobeIn(strobe), .generalPinOut(gpOut), .generalPinOe_n(gpOe_n), .loopClkRef(loopRef),
    .jackDetect(jackDetect), .tempOk(1'b0), .autoMuteActive(1'b0), .loopLock(1'b0),
    .wordValid(wordValid), .wordAddr(wordAddr), .wordData(wordData), .pinControl(pinControl));
  serial_host_model host (.sys_clk(sys_clk), .sdaLevel(sda), .serialClk(sclk),
    .sdaDrive(hostSda), .strobeOut(strobe));
  always @(posedge sys_clk) if (wordValid === 1'b1) begin
    words++;
    lastWord = {wordAddr, wordData};
  end
  task automatic check(input logic [15:0] wd, input logic hit, input int expAck);
    repeat (8) @(posedge sys_clk);
    if (hit) begin
      expWords++;
      if (wd[15:9] == `SOFT_RESET_ADDR) expPin = `PIN_CTRL_RESET;
      else if (wd[15:9] == `PIN_CTRL_ADDR) expPin = wd[8:0];
      `CHK("word", wd, lastWord)
    end
    `CHK("count", expWords, words)
    `CHK("pinctl", expPin, pinControl)
    `CHK("acks", expAck, ack)
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========
  // Tests
  initial begin
    w = 16'($urandom(32'hEBC27F39));
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    `CHK("pin reset", `PIN_CTRL_RESET, pinControl)
    // Extra leading bit: only the last 16 may land
    for (int k = 0; k < 3; k++) begin
      w = {(k == 2) ? `SOFT_RESET_ADDR : `PIN_CTRL_ADDR, 9'($urandom)};
      host.wr3({1'($urandom), w});
      check(w, 1'b1, 0);
    end
    modePin <= 1'b0;
    w = {`PIN_CTRL_ADDR, 9'h009};
    host.wr2({`DEV_ADDR, 1'b0, w}, 24, ack);
    check(w, 1'b1, 3);
    `CHK("gp oe", 1'b0, gpOe_n)
    `CHK("gp inv", 1'b1, gpOut)
    jackDetect <= 1'b1;
    repeat (6) @(posedge sys_clk);
    `CHK("gp jack", 1'b0, gpOut)
    // Reference enabled every cycle: divide by d+1 toggles every d+1 cycles
    loopRef <= 1'b1;
    for (int d = 1; d < 3; d++) begin
      w = {`PIN_CTRL_ADDR, 3'h0, 2'(d), 1'b0, `SEL_LOOP_CLK};
      host.wr2({`DEV_ADDR, 1'b0, w}, 24, ack);
      check(w, 1'b1, 3);
      edges = 0;
      @(negedge sys_clk);
      repeat (48) begin
        g = gpOut;
        @(negedge sys_clk);
        edges += int'(g !== gpOut);
      end
      `CHK("div edges", 48 / (d + 1), edges)
    end
    loopRef <= 1'b0;
    // Wrong address, read, abort, good word, soft reset
    for (int k = 0; k < 5; k++) begin
      w = {(k == 4) ? `SOFT_RESET_ADDR : `PIN_CTRL_ADDR, 9'($urandom)};
      host.wr2({`DEV_ADDR ^ {6'h00, k == 0}, k == 1, w}, (k == 2) ? 12 : 24, ack);
      check(w, k > 2, (k < 2) ? 0 : ((k == 2) ? 1 : 3));
    end
    host.wr3(17'h1FFFF);
    ack = 0;
    check(w, 1'b0, 0);
    wrap_up;
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    fails++;
    wrap_up;
  end
endmodule // tb
bind serial_control_port serial_ctrl_checker chk (.sys_clk(sys_clk), .reset(reset),
  .modePin(modePin), .serialDataOe_n(serialDataOe_n), .generalPinOe_n(generalPinOe_n),
  .wordValid(wordValid), .wordAddr(wordAddr), .wordData(wordData), .pinControl(pinControl));
